// ==== vfd_pkg.sv ====
// shared constants and types for the vliw fetch and dispatch block
package vfd_pkg;
  // ------------------------------------------------------------
  // fetch packet geometry
  // ------------------------------------------------------------
  localparam int FP_WORDS = 8;
  localparam int IW = 32;
  localparam int FP_BITS = FP_WORDS * IW;
  localparam logic [31:0] FP_BYTES = 32'h0000_0020;
  localparam logic [31:0] RESET_PC = 32'h0000_0000;
  localparam int CHAIN_BIT = 0;
  localparam logic [3:0] EP_MAX = 4'h8;
  localparam logic [2:0] LAST_SLOT = 3'h7;
  // ------------------------------------------------------------
  // functional unit constants
  // ------------------------------------------------------------
  localparam logic [7:0] GF_POLY = 8'h1D;
  localparam int DW = 64;
  localparam logic [7:0] BE_BYTE = 8'h01;
  localparam logic [7:0] BE_HALF = 8'h03;
  localparam logic [7:0] BE_WORD = 8'h0F;
  localparam logic [7:0] BE_DBL = 8'hFF;

  typedef enum logic [3:0] {
    M_DUAL16 = 4'h0,
    M_QUAD8 = 4'h1,
    M_MPY1632 = 4'h2,
    M_DOTADD = 4'h3,
    M_DOTSUB = 4'h4,
    M_QUADADD = 4'h5,
    M_BITCNT = 4'h6,
    M_ROTL = 4'h7,
    M_GFMPY = 4'h8,
    M_SHIFT = 4'h9
  } vfd_mop_t;

  typedef enum logic [3:0] {
    A_ADD = 4'h0,
    A_SUB = 4'h1,
    A_ADD2 = 4'h2,
    A_SUB2 = 4'h3,
    A_ADD4 = 4'h4,
    A_SUB4 = 4'h5,
    A_AND = 4'h6,
    A_OR = 4'h7,
    A_XOR = 4'h8
  } vfd_aop_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2,
    SZ_DBL = 2'h3
  } vfd_lsz_t;
endpackage

// ==== vfd_fetch_dispatch.sv ====
// vliw fetch, execute packet dispatch and functional unit datapaths
// Notes on behaviour
// - fetch packets are 256 bits, eight 32-bit instruction words
// - lsb one chains the following word into the same execute packet
// - lsb zero ends the execute packet; next word starts a new one
// - at most eight instructions per execute packet, issued in one cycle
// - execute packets may cross fetch packet boundaries without padding
// - one to eight execute packets may sit in one fetch packet
// - at most one execute packet issued per clock
// - next fetch only after all packets of current fetch dispatched
// - each multiply unit does two 16x16 or four 8x8 multiplies per cycle
// - multiply units also do 16x32, dot add/sub, quad add, bitcount, etc.
// - logic units give packed 32, dual 16, quad 8 results every cycle
// - load/store sizes are byte, half-word, word or doubleword
// - wide multiply result: upper 32 to long dst, lower 32 to dst
`timescale 1ns/1ps
`default_nettype none
module vfd_fetch_dispatch #(
  parameter int NMUL = 2,
  parameter int NALU = 4,
  parameter int NLSU = 2
) (
  input wire logic clk,
  input wire logic rst,
  output logic fetch_req_r,
  output logic [31:0] fetch_addr_r,
  input wire logic fetch_valid,
  input wire logic [vfd_pkg::FP_BITS-1:0] fetch_data,
  output logic issue_valid_r,
  output logic [3:0] issue_count_r,
  output logic [vfd_pkg::FP_BITS-1:0] issue_words_r,
  input wire vfd_pkg::vfd_mop_t mul_op [NMUL],
  input wire logic [31:0] mul_a [NMUL],
  input wire logic [31:0] mul_b [NMUL],
  output logic [31:0] mul_hi_r [NMUL],
  output logic [31:0] mul_lo_r [NMUL],
  input wire vfd_pkg::vfd_aop_t alu_op [NALU],
  input wire logic [31:0] alu_a [NALU],
  input wire logic [31:0] alu_b [NALU],
  output logic [31:0] alu_r [NALU],
  input wire vfd_pkg::vfd_lsz_t ls_size [NLSU],
  input wire logic [2:0] ls_addr [NLSU],
  input wire logic [63:0] ls_wdata [NLSU],
  output logic [7:0] ls_be_r [NLSU],
  output logic [63:0] ls_data_r [NLSU]
);
  import vfd_pkg::*;

  // ------------------------------------------------------------
  // fetch buffer and execute packet assembly
  // ------------------------------------------------------------
  logic [FP_BITS-1:0] buf_r;
  logic buf_vld_r;
  logic [2:0] pos_r;
  logic [IW-1:0] acc_w_r [FP_WORDS];
  logic [3:0] acc_cnt_r;
  logic [IW-1:0] ew [FP_WORDS];
  logic [3:0] n;
  logic brk;
  logic [2:0] last;
  logic take;
  logic fp_done;
  logic ep_issue;

  assign take = fetch_req_r && fetch_valid;

  always_comb begin
    n = acc_cnt_r;
    brk = 1'b0;
    last = 3'h0;
    ew = acc_w_r;
    for (int i = 0; i < FP_WORDS; i++) begin
      if (buf_vld_r && 3'(i) >= pos_r && !brk && n < EP_MAX) begin
        ew[n[2:0]] = buf_r[i*IW +: IW];
        n = n + 4'h1;
        last = 3'(i);
        if (!buf_r[i*IW+CHAIN_BIT] || n == EP_MAX) begin
          brk = 1'b1;
        end
      end
    end
  end

  assign ep_issue = buf_vld_r && brk;
  // open chain at the end carries over
  assign fp_done = buf_vld_r && (!brk || last == LAST_SLOT);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_r <= '0;
      buf_vld_r <= 1'b0;
    end else if (take) begin
      buf_r <= fetch_data;
      buf_vld_r <= 1'b1;
    end else if (fp_done) begin
      buf_vld_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_r <= 3'h0;
    end else if (take) begin
      pos_r <= 3'h0;
    end else if (ep_issue) begin
      pos_r <= last + 3'h1;
    end
  end

  // carried words survive until the next packet closes them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_cnt_r <= 4'h0;
      for (int i = 0; i < FP_WORDS; i++) begin
        acc_w_r[i] <= '0;
      end
    end else if (ep_issue) begin
      acc_cnt_r <= 4'h0;
    end else if (fp_done) begin
      acc_cnt_r <= n;
      acc_w_r <= ew;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetch_req_r <= 1'b0;
      fetch_addr_r <= RESET_PC;
    end else if (take) begin
      fetch_req_r <= 1'b0;
      fetch_addr_r <= fetch_addr_r + FP_BYTES;
    end else if (fp_done || !buf_vld_r) begin
      fetch_req_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      issue_valid_r <= 1'b0;
      issue_count_r <= 4'h0;
      issue_words_r <= '0;
    end else begin
      issue_valid_r <= ep_issue;
      if (ep_issue) begin
        issue_count_r <= n;
        for (int i = 0; i < FP_WORDS; i++) begin
          issue_words_r[i*IW +: IW] <= (4'(i) < n) ? ew[i] : '0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // functional unit helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int k = 0; k < 8; k++) begin
      if (b[k]) p = p ^ x;
      x = x[7] ? ((x << 1) ^ GF_POLY) : (x << 1);
    end
    return p;
  endfunction

  // lane width in bytes: 4, 2 or 1; carry is cut at lane edges
  function automatic logic [31:0] lane_add(input logic [31:0] a, input logic [31:0] b,
                                           input logic sub, input int lane);
    logic [31:0] r;
    logic [8:0] s;
    logic c;
    r = '0;
    c = sub;
    for (int k = 0; k < 4; k++) begin
      if (k % lane == 0) c = sub;
      s = {1'b0, a[k*8 +: 8]} + {1'b0, sub ? ~b[k*8 +: 8] : b[k*8 +: 8]} + {8'h00, c};
      r[k*8 +: 8] = s[7:0];
      c = s[8];
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // multiply units
  // ------------------------------------------------------------
  for (genvar u = 0; u < NMUL; u++) begin : g_mul
    logic [31:0] p16 [2];
    logic [15:0] p8 [4];
    logic [47:0] p48;
    logic [63:0] res;
    logic [5:0] sh;
    always_comb begin
      sh = 6'(-$signed(mul_b[u][5:0]));
      for (int k = 0; k < 2; k++) p16[k] = mul_a[u][k*16 +: 16] * mul_b[u][k*16 +: 16];
      for (int k = 0; k < 4; k++) p8[k] = mul_a[u][k*8 +: 8] * mul_b[u][k*8 +: 8];
      p48 = mul_a[u][15:0] * mul_b[u];
      res = '0;
      unique case (mul_op[u])
        M_DUAL16: res = {p16[1], p16[0]};
        M_QUAD8: res = {p8[3], p8[2], p8[1], p8[0]};
        M_MPY1632: res = {16'h0000, p48};
        M_DOTADD: res = {32'h0, p16[0] + p16[1]};
        M_DOTSUB: res = {32'h0, p16[1] - p16[0]};
        // summed at full width so four large products keep their carry
        M_QUADADD: res = {32'h0, 32'(p8[0]) + 32'(p8[1]) + 32'(p8[2]) + 32'(p8[3])};
        M_BITCNT: begin
          for (int k = 0; k < 4; k++) res[k*8 +: 8] = 8'($countones(mul_a[u][k*8 +: 8]));
        end
        M_ROTL: res = {32'h0, (mul_a[u] << mul_b[u][4:0]) |
                              (mul_a[u] >> (6'h20 - {1'b0, mul_b[u][4:0]}))};
        M_GFMPY: begin
          for (int k = 0; k < 4; k++) res[k*8 +: 8] = gf_mul(mul_a[u][k*8 +: 8], mul_b[u][k*8 +: 8]);
        end
        // negative amount shifts right
        M_SHIFT: res = {32'h0, mul_b[u][5] ? (mul_a[u] >> sh) : (mul_a[u] << mul_b[u][5:0])};
        default: res = '0;
      endcase
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        mul_hi_r[u] <= '0;
        mul_lo_r[u] <= '0;
      end else begin
        mul_hi_r[u] <= res[63:32];
        mul_lo_r[u] <= res[31:0];
      end
    end
  end

  // ------------------------------------------------------------
  // arithmetic/logic units
  // ------------------------------------------------------------
  // packed results every cycle
  for (genvar u = 0; u < NALU; u++) begin : g_alu
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        alu_r[u] <= '0;
      end else begin
        unique case (alu_op[u])
          A_ADD: alu_r[u] <= lane_add(alu_a[u], alu_b[u], 1'b0, 4);
          A_SUB: alu_r[u] <= lane_add(alu_a[u], alu_b[u], 1'b1, 4);
          A_ADD2: alu_r[u] <= lane_add(alu_a[u], alu_b[u], 1'b0, 2);
          A_SUB2: alu_r[u] <= lane_add(alu_a[u], alu_b[u], 1'b1, 2);
          A_ADD4: alu_r[u] <= lane_add(alu_a[u], alu_b[u], 1'b0, 1);
          A_SUB4: alu_r[u] <= lane_add(alu_a[u], alu_b[u], 1'b1, 1);
          A_AND: alu_r[u] <= alu_a[u] & alu_b[u];
          A_OR: alu_r[u] <= alu_a[u] | alu_b[u];
          A_XOR: alu_r[u] <= alu_a[u] ^ alu_b[u];
          default: alu_r[u] <= '0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // load/store lane steering
  // ------------------------------------------------------------
  // lanes past byte seven are dropped; a misaligned access that wraps is split upstream
  for (genvar u = 0; u < NLSU; u++) begin : g_lsu
    logic [7:0] be;
    always_comb begin
      unique case (ls_size[u])
        SZ_BYTE: be = BE_BYTE;
        SZ_HALF: be = BE_HALF;
        SZ_WORD: be = BE_WORD;
        SZ_DBL: be = BE_DBL;
      endcase
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ls_be_r[u] <= '0;
        ls_data_r[u] <= '0;
      end else begin
        ls_be_r[u] <= be << ls_addr[u];
        ls_data_r[u] <= ls_wdata[u] << {ls_addr[u], 3'h0};
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  logic chain_ok;
  always_comb begin
    chain_ok = 1'b1;
    for (int i = 0; i < FP_WORDS - 1; i++) begin
      if (4'(i + 1) < issue_count_r && !issue_words_r[i*IW+CHAIN_BIT]) chain_ok = 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_fetch_gated: assert property (buf_vld_r |-> !fetch_req_r)
    else $error("fetch requested while packet still dispatching");
  a_fetch_step: assert property (take |=> fetch_addr_r == $past(fetch_addr_r) + FP_BYTES)
    else $error("fetch address did not advance one packet");
  a_issue_size: assert property (issue_valid_r |-> issue_count_r inside {[4'h1:EP_MAX]})
    else $error("execute packet size out of range");
  a_chain_inner: assert property (issue_valid_r |-> chain_ok)
    else $error("chained word missing from execute packet");
  a_chain_end: assert property (ep_issue && n != EP_MAX |-> !ew[n[2:0]-3'h1][CHAIN_BIT])
    else $error("execute packet closed on a chained word");
  a_carry_keep: assert property (fp_done && !brk |=> acc_cnt_r != 4'h0 && fetch_req_r)
    else $error("open chain not carried to next fetch");
  a_mul_dual: assert property (mul_op[0] == M_DUAL16 |=>
      mul_lo_r[0] == 32'($past(mul_a[0][15:0]) * $past(mul_b[0][15:0])))
    else $error("dual multiply low product wrong");
  a_mul_wide: assert property (mul_op[0] == M_MPY1632 |=>
      {mul_hi_r[0], mul_lo_r[0]} == 64'($past(mul_a[0][15:0]) * $past(mul_b[0])))
    else $error("wide product halves misplaced");
  a_alu_add: assert property (alu_op[0] == A_ADD |=> alu_r[0] == $past(alu_a[0]) + $past(alu_b[0]))
    else $error("32-bit add result wrong");
  a_lsu_word: assert property (ls_size[0] == SZ_WORD && ls_addr[0] == 3'h0 |=> ls_be_r[0] == BE_WORD)
    else $error("word store byte enables wrong");
endmodule // vfd_fetch_dispatch
`default_nettype wire

// ==== vfd_pmem.sv ====
// program memory model serving fetch packets on request
`timescale 1ns/1ps
`default_nettype none
module vfd_pmem (
  input wire logic clk,
  input wire logic rst,
  input wire logic fetch_req_r,
  input wire logic [31:0] fetch_addr_r,
  input wire logic [1:0] dly,
  input wire logic [7:0] lim,
  output logic fetch_valid,
  output logic [255:0] fetch_data,
  output logic [7:0] n_bad
);
  logic [31:0] mem [0:95];
  logic [7:0] k;
  logic [1:0] w;
  // ----------------------------------------
  // answer path
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetch_valid <= 1'b0;
      fetch_data <= '0;
      k <= 8'h00;
      w <= 2'h0;
      n_bad <= 8'h00;
    end else if (fetch_valid) begin
      // taken here, the request is held until then; data never lingers
      fetch_valid <= 1'b0;
      fetch_data <= ~fetch_data;
      k <= k + 8'h01;
    end else if (fetch_req_r && k < lim && w == 2'h0) begin
      fetch_valid <= 1'b1;
      for (int i = 0; i < 8; i++) fetch_data[32*i +: 32] <= mem[8*k + i];
      if (fetch_addr_r !== {19'h0, k, 5'h00}) n_bad <= n_bad + 8'h01;
      w <= dly;
    end else begin
      fetch_data <= ~fetch_data;
      if (w != 2'h0) w <= w - 2'h1;
    end
  end
endmodule // vfd_pmem
`default_nettype wire

// ==== tb.sv ====
// self-checking testbench for the fetch and dispatch block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vfd_pkg::*;
  typedef struct packed {
    logic [3:0] cnt;
    logic [255:0] w;
  } vfd_pkt_t;
  typedef struct packed {
    logic [31:0] cyc;
    logic [1:0][63:0] m;
    logic [3:0][31:0] a;
    logic [1:0][7:0] be;
    logic [1:0][63:0] d;
  } vfd_uexp_t;
  logic clk, rst, fetch_req_r, fetch_valid, issue_valid_r;
  logic [31:0] fetch_addr_r, cyc, wd;
  logic [255:0] fetch_data, issue_words_r;
  logic [3:0] issue_count_r;
  vfd_mop_t mul_op [2];
  logic [31:0] mul_a [2], mul_b [2], mul_hi_r [2], mul_lo_r [2];
  vfd_aop_t alu_op [4];
  logic [31:0] alu_a [4], alu_b [4], alu_r [4];
  vfd_lsz_t ls_size [2];
  logic [2:0] ls_addr [2];
  logic [63:0] ls_wdata [2], ls_data_r [2];
  logic [7:0] ls_be_r [2], n_bad, lim;
  logic [1:0] dly;
  int fail_count, n_compared, takes, nw, c, to;
  int xw [13];
  int dens [12] = '{0, 4, 0, 8, 8, 6, 2, 7, 1, 5, 3, 8};
  vfd_pkt_t iq [$];
  vfd_pkt_t p, pc;
  vfd_uexp_t uq [$];
  vfd_uexp_t u;

  vfd_fetch_dispatch dut (.clk(clk), .rst(rst), .fetch_req_r(fetch_req_r),
    .fetch_addr_r(fetch_addr_r), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
    .issue_valid_r(issue_valid_r), .issue_count_r(issue_count_r),
    .issue_words_r(issue_words_r), .mul_op(mul_op), .mul_a(mul_a), .mul_b(mul_b),
    .mul_hi_r(mul_hi_r), .mul_lo_r(mul_lo_r), .alu_op(alu_op), .alu_a(alu_a),
    .alu_b(alu_b), .alu_r(alu_r), .ls_size(ls_size), .ls_addr(ls_addr),
    .ls_wdata(ls_wdata), .ls_be_r(ls_be_r), .ls_data_r(ls_data_r));
  vfd_pmem pm (.clk(clk), .rst(rst), .fetch_req_r(fetch_req_r), .fetch_addr_r(fetch_addr_r),
    .dly(dly), .lim(lim), .fetch_valid(fetch_valid), .fetch_data(fetch_data), .n_bad(n_bad));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc <= rst ? 32'h0 : cyc + 32'h1;

  task automatic cmp(input string nm, input logic [255:0] e, input logic [255:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d compared %0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // unit models
  // ----------------------------------------
  // carry-less product first, then reduced by the field polynomial
  function automatic logic [7:0] gexp(logic [7:0] a, logic [7:0] b);
    logic [15:0] t;
    t = 16'h0000;
    for (int i = 0; i < 8; i++) if (b[i]) t = t ^ (16'(a) << i);
    for (int i = 15; i >= 8; i--) if (t[i]) t = t ^ ({8'h01, GF_POLY} << (i - 8));
    return t[7:0];
  endfunction

  function automatic logic [63:0] mexp(vfd_mop_t op, logic [31:0] a, logic [31:0] b);
    logic [15:0] q [4];
    logic [31:0] q0, q1;
    logic [31:0] r;
    int s;
    for (int i = 0; i < 4; i++) q[i] = a[8*i +: 8] * b[8*i +: 8];
    q0 = a[15:0] * b[15:0];
    q1 = a[31:16] * b[31:16];
    s = int'($signed(b[5:0]));
    case (op)
      M_DUAL16: return {q1, q0};
      M_QUAD8: return {q[3], q[2], q[1], q[0]};
      M_MPY1632: return 64'(a[15:0]) * 64'(b);
      M_DOTADD: return {32'h0, q0 + q1};
      M_DOTSUB: return {32'h0, q1 - q0};
      M_QUADADD: return {32'h0, 32'(q[0]) + 32'(q[1]) + 32'(q[2]) + 32'(q[3])};
      M_BITCNT: begin
        for (int i = 0; i < 4; i++) r[8*i +: 8] = 8'($countones(a[8*i +: 8]));
        return {32'h0, r};
      end
      M_GFMPY: begin
        for (int i = 0; i < 4; i++) r[8*i +: 8] = gexp(a[8*i +: 8], b[8*i +: 8]);
        return {32'h0, r};
      end
      M_SHIFT: return {32'h0, (s < 0) ? (a >> (-s)) : (a << s)};
      default: return {32'h0, 32'((a << b[4:0]) | (a >> (6'h20 - b[4:0])))};
    endcase
  endfunction

  function automatic logic [31:0] aexp(vfd_aop_t op, logic [31:0] a, logic [31:0] b);
    logic [31:0] r;
    case (op)
      A_ADD: r = a + b;
      A_SUB: r = a - b;
      A_ADD2: r = {a[31:16] + b[31:16], a[15:0] + b[15:0]};
      A_SUB2: r = {a[31:16] - b[31:16], a[15:0] - b[15:0]};
      A_AND: r = a & b;
      A_OR: r = a | b;
      A_XOR: r = a ^ b;
      default: for (int i = 0; i < 4; i++) r[8*i +: 8] = (op == A_ADD4) ?
        a[8*i +: 8] + b[8*i +: 8] : a[8*i +: 8] - b[8*i +: 8];
    endcase
    return r;
  endfunction

  task automatic units(input int n);
    vfd_uexp_t e;
    repeat (n) begin
      @(negedge clk);
      e.cyc = cyc;
      for (int i = 0; i < 2; i++) begin
        mul_op[i] = vfd_mop_t'($urandom_range(9));
        mul_a[i] = $urandom;
        mul_b[i] = $urandom;
        e.m[i] = mexp(mul_op[i], mul_a[i], mul_b[i]);
        ls_size[i] = vfd_lsz_t'($urandom_range(3));
        ls_addr[i] = 3'($urandom);
        ls_wdata[i] = {$urandom, $urandom};
        e.be[i] = 8'(((16'h1 << (16'h1 << ls_size[i])) - 16'h1) << ls_addr[i]);
        e.d[i] = ls_wdata[i] << (8 * ls_addr[i]);
      end
      for (int i = 0; i < 4; i++) begin
        alu_op[i] = vfd_aop_t'($urandom_range(8));
        alu_a[i] = $urandom;
        alu_b[i] = $urandom;
        e.a[i] = aexp(alu_op[i], alu_a[i], alu_b[i]);
      end
      uq.push_back(e);
    end
  endtask

  // results land one edge after operands, so only older notes are due
  always @(negedge clk) if (uq.size() > 0 && uq[0].cyc < cyc) begin
    u = uq.pop_front();
    for (int i = 0; i < 2; i++) begin
      cmp("mul", u.m[i], {mul_hi_r[i], mul_lo_r[i]});
      cmp("be", u.be[i], ls_be_r[i]);
      cmp("lsdata", u.d[i], ls_data_r[i]);
    end
    for (int i = 0; i < 4; i++) cmp("alu", u.a[i], alu_r[i]);
  end

  // looked at mid-cycle, where registered outputs have settled
  always @(negedge clk) if (!rst) begin
    if (issue_valid_r) begin
      if (iq.size() == 0) cmp("extra issue", 0, 1);
      else begin
        pc = iq.pop_front();
        cmp("count", pc.cnt, issue_count_r);
        cmp("words", pc.w, issue_words_r);
        nw += int'(issue_count_r);
      end
    end
    if (fetch_req_r && fetch_valid) begin
      cmp("issued at fetch", xw[takes], nw);
      takes++;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hFDD5BA19));
    rst = 1'b1;
    lim = 8'h00;
    dly = 2'h0;
    for (int i = 0; i < 2; i++) begin
      mul_op[i] = M_DUAL16;
      {mul_a[i], mul_b[i]} = '0;
      ls_size[i] = SZ_BYTE;
      {ls_addr[i], ls_wdata[i]} = '0;
    end
    for (int i = 0; i < 4; i++) begin
      alu_op[i] = A_ADD;
      {alu_a[i], alu_b[i]} = '0;
    end
    // first packet 1,0,0 then an open chain that carries over
    p = '0;
    for (int j = 0; j < 96; j++) begin
      wd = $urandom;
      wd[0] = (j < 8) ? 1'(8'hF9 >> j) : (j == 8 || j == 95) ? 1'b0 :
        1'($urandom_range(7) < dens[j/8]);
      pm.mem[j] = wd;
      p.w[32*c +: 32] = wd;
      c++;
      if (!wd[0] || c == 8) begin
        p.cnt = 4'(c);
        iq.push_back(p);
        p = '0;
        c = 0;
      end
      if (j % 8 == 7) xw[j/8 + 1] = j + 1 - c;
    end
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    lim = 8'h0C;
    fork
      units(400);
      for (to = 0; to < 3000 && (iq.size() > 0 || takes < 12); to++) begin
        @(negedge clk);
        dly = 2'($urandom_range(3));
      end
    join
    if (to == 3000) cmp("timeout", 0, 1);
    repeat (10) @(negedge clk);
    cmp("bad addr", 0, n_bad);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
